/* File: hw/asc_pkg.sv */
// package: constants and carriers for the async sram host controller
package asc_pkg;
  // memory geometry
  localparam int ADDR_W = 17;
  localparam int DATA_W = 8;
  // clock period in picoseconds (125 MHz)
  localparam int CLK_PS = 8000;
  // timing figures in ns for the 10 ns grade (default)
  localparam int T_RC_NS   = 10;  // read cycle time
  localparam int T_AA_NS   = 10;  // address access time
  localparam int T_WP_NS   = 7;   // write pulse width
  localparam int T_DW_NS   = 5;   // data_setup_to_write_end
  localparam int T_WHZ_NS  = 5;   // write enable to output high-z
  localparam int T_OHZ_NS  = 5;   // output disable to high-z
  localparam int T_OW_NS   = 3;   // output active from end of write
  localparam int T_OH_NS   = 4;   // output_hold_after_address

  // least time in ns to whole cycles, at least one
  function automatic int ns_to_cyc(input int ns);
    int c;
    c = (ns * 1000 + CLK_PS - 1) / CLK_PS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int RD_CYC  = ns_to_cyc(T_AA_NS + 1);  // access plus sample margin
  localparam int WR_CYC  = ns_to_cyc(T_WHZ_NS + T_DW_NS);
  localparam int TA_CYC  = ns_to_cyc(T_OHZ_NS);
  localparam int REC_CYC = ns_to_cyc(T_RC_NS);
  localparam int SYNC_CYC = 4;  // edges from a settled pin to the synchroniser output

  // host request
  typedef struct packed {
    logic              we;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } asc_req_s;

  // sram pin bundle driven by the controller
  typedef struct packed {
    logic              cs_n;
    logic              oe_n;
    logic              we_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq_out;
    logic              dq_oe;
  } asc_pins_s;
endpackage

/* File: hw/asc_sync.sv */
// three-stage input synchroniser for the sram data pins
`timescale 1ns/1ps
module asc_sync
  import asc_pkg::*;
#(
  parameter int W = 8
)(
  input  wire logic         mclk_i,  // system clock
  input  wire logic         rst_i,   // async reset
  input  wire logic [W-1:0] d_i,     // raw pin level
  output logic      [W-1:0] q_o      // stable level
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] q_q;
  // q follows once second and third stages agree
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      q_q  <= '0;
    end
    else
    begin
      s1_q <= d_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q)
        q_q <= s3_q;
    end
  end
  assign q_o = q_q;
endmodule

/* File: hw/asc_ctrl.sv */
// host controller driving a 128k x 8 asynchronous static ram
`timescale 1ns/1ps
module asc_ctrl
  import asc_pkg::*;
#(
  parameter int AW = ADDR_W,
  parameter int DW = DATA_W
)(
  input  wire logic          mclk_i,    // 125 MHz clock
  input  wire logic          rst_i,     // async reset, active high
  input  wire logic          req_i,     // request valid
  input  wire logic          req_we_i,  // 1 write, 0 read
  input  wire logic [AW-1:0] req_addr_i,// request address
  input  wire logic [DW-1:0] req_wd_i,  // write data
  output logic               ready_o,   // idle, takes a request
  output logic               rvalid_o,  // read data pulse
  output logic      [DW-1:0] rdata_o,   // read data
  output logic               cs_n_o,    // sram chip select
  output logic               oe_n_o,    // sram output enable
  output logic               we_n_o,    // sram write enable
  output logic      [AW-1:0] addr_o,    // sram address
  output logic      [DW-1:0] dq_o,      // data to sram
  output logic               dq_oe_o,   // high while we drive dq
  input  wire logic [DW-1:0] dq_i       // data from sram pins
);
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_SETUP = 3'b001,
    ST_READ  = 3'b010,
    ST_WRITE = 3'b011,
    ST_TURN  = 3'b100,
    ST_REC   = 3'b101
  } asc_state_e;

  localparam int CW = 4;

  asc_state_e  st_q, st_d;
  logic [CW-1:0] cnt_q, cnt_d;
  asc_req_s    req_q;
  asc_pins_s   pin_q, pin_d;
  logic        rvalid_q;
  logic [DW-1:0] rdata_q;
  logic [DW-1:0] dq_sync;

  // dq arrives from another domain, so it is resynchronised
  asc_sync #(.W(DW)) u_sync (
    .mclk_i (mclk_i),
    .rst_i  (rst_i),
    .d_i    (dq_i),
    .q_o    (dq_sync)
  );

  // decode of the current phase
  wire take     = (st_q == ST_IDLE) && req_i;
  wire cnt_done = (cnt_q == '0);
  wire rd_done  = (st_q == ST_READ) && cnt_done;

  // sequencer; phase lengths from package counts
  always_comb
  begin
    st_d  = st_q;
    cnt_d = cnt_done ? cnt_q : cnt_q - 1'b1;
    pin_d = pin_q;
    unique case (st_q)
      ST_IDLE:
      begin
        pin_d.cs_n  = 1'b1;                     // standby between cycles
        pin_d.oe_n  = 1'b1;
        pin_d.we_n  = 1'b1;
        pin_d.dq_oe = 1'b0;
        if (req_i)
        begin
          pin_d.addr   = req_addr_i;            // address before select
          pin_d.dq_out = req_wd_i;
          st_d         = ST_SETUP;
        end
      end
      ST_SETUP:
      begin
        pin_d.cs_n = 1'b0;
        if (req_q.we)
        begin
          pin_d.we_n  = 1'b0;                   // we with cs keeps sram off bus
          pin_d.oe_n  = 1'b1;                   // plain pulse width suffices
          pin_d.dq_oe = 1'b1;                   // oe stays high, so no contention
          cnt_d       = CW'(WR_CYC - 1);        // covers turnoff plus setup
          st_d        = ST_WRITE;
        end
        else
        begin
          pin_d.oe_n = 1'b0;                    // read strobes
          // strobes stay low until the byte has crossed the synchroniser;
          // costs four edges per read but never samples a released bus
          cnt_d      = CW'(RD_CYC + SYNC_CYC - 1);
          st_d       = ST_READ;
        end
      end
      ST_READ:
        if (cnt_done)
        begin
          pin_d.cs_n = 1'b1;
          pin_d.oe_n = 1'b1;
          cnt_d      = CW'(TA_CYC - 1);         // sram driver release time
          st_d       = ST_TURN;
        end
      ST_WRITE:
        if (cnt_done)
        begin
          pin_d.we_n = 1'b1;                    // write ends, cs still low
          st_d       = ST_TURN;
          cnt_d      = '0;
        end
      ST_TURN:
        if (cnt_done)
        begin
          pin_d.cs_n  = 1'b1;
          pin_d.dq_oe = 1'b0;                   // data hold zero, release after we
          cnt_d       = CW'(REC_CYC - 1);
          st_d        = ST_REC;
        end
      ST_REC:
        if (cnt_done)
          st_d = ST_IDLE;                       // spacing of cycles
      default:
        st_d = ST_IDLE;
    endcase
  end

  // state, request capture and pins
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st_q  <= ST_IDLE;
      cnt_q <= '0;
      req_q <= '0;
      pin_q <= '{cs_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: '0, dq_out: '0, dq_oe: 1'b0};
    end
    else
    begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
      pin_q <= pin_d;
      if (take)
        req_q <= '{we: req_we_i, addr: req_addr_i, wdata: req_wd_i};
    end
  end

  // read data sampled at end of access, before select drops
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
    end
    else
    begin
      rvalid_q <= rd_done;
      if (rd_done)
        rdata_q <= dq_sync;
    end
  end

  // ready registered from next state
  logic ready_q;
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      ready_q <= 1'b0;
    else
      ready_q <= (st_d == ST_IDLE) && !(st_q == ST_IDLE && req_i);
  end

  assign ready_o  = ready_q;
  assign rvalid_o = rvalid_q;
  assign rdata_o  = rdata_q;
  assign cs_n_o   = pin_q.cs_n;
  assign oe_n_o   = pin_q.oe_n;
  assign we_n_o   = pin_q.we_n;
  assign addr_o   = pin_q.addr;
  assign dq_o     = pin_q.dq_out;
  assign dq_oe_o  = pin_q.dq_oe;

  // assertions
  sequence s_wr_start;
    !pin_q.cs_n && !pin_q.we_n;
  endsequence

  AST_NO_CONTENTION: assert property (@(posedge mclk_i) disable iff (rst_i)
    pin_q.dq_oe |-> pin_q.oe_n)
    else $error("data driven while output enable low");
  AST_WRITE_PULSE: assert property (@(posedge mclk_i) disable iff (rst_i)
    $fell(pin_q.we_n) |-> !pin_q.we_n [*2])
    else $error("write pulse too short");
  AST_WRITE_CS: assert property (@(posedge mclk_i) disable iff (rst_i)
    s_wr_start ##1 $rose(pin_q.we_n) |-> !pin_q.cs_n)
    else $error("select left before end of write");
  AST_WE_OE_EXCL: assert property (@(posedge mclk_i) disable iff (rst_i)
    !(!pin_q.we_n && !pin_q.oe_n))
    else $error("write and read strobes together");
  AST_ADDR_STABLE: assert property (@(posedge mclk_i) disable iff (rst_i)
    !pin_q.cs_n && !$past(pin_q.cs_n) |-> $stable(pin_q.addr))
    else $error("address moved while selected");
  // read strobe spans access plus synchroniser latency (RD_CYC + SYNC_CYC)
  sequence s_rd_strobe;
    !pin_q.oe_n [*6];
  endsequence

  AST_READ_LEN: assert property (@(posedge mclk_i) disable iff (rst_i)
    $fell(pin_q.oe_n) |-> s_rd_strobe ##1 (rvalid_q && pin_q.oe_n))
    else $error("read data not returned on time");
  AST_DQ_HOLD: assert property (@(posedge mclk_i) disable iff (rst_i)
    $rose(pin_q.we_n) |-> pin_q.dq_oe)
    else $error("data released before write end");
  AST_IDLE_GAP: assert property (@(posedge mclk_i) disable iff (rst_i)
    $rose(pin_q.cs_n) |-> pin_q.cs_n [*2])
    else $error("deselect gap too short");
endmodule

/* File: sim/asc_sram_model.sv */
// behavioural 128k x 8 asynchronous sram on the controller pins
`timescale 1ns/1ps
module asc_sram_model
  import asc_pkg::*;
#(
  parameter realtime T_ACC  = 1.0,  // address access delay in ns
  parameter realtime T_HOLD = 1.0   // output hold after address change in ns
)(
  input  wire logic              cs_n_i,  // chip select
  input  wire logic              oe_n_i,  // output enable
  input  wire logic              we_n_i,  // write enable
  input  wire logic [ADDR_W-1:0] addr_i,  // address
  input  wire logic [DATA_W-1:0] dq_i,    // host write data
  input  wire logic              dq_oe_i, // host drives dq
  output logic      [DATA_W-1:0] dq_o     // resolved pin level
);
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  logic [DATA_W-1:0] held = '0;
  wire               rd = !cs_n_i && !oe_n_i && we_n_i;
  wire               wr = !cs_n_i && !we_n_i;
  wire               rd_v;
  wire [ADDR_W-1:0]  addr_h;
  wire [DATA_W-1:0]  rd_byte;
  // access delay, also after a write ends; no clock or refresh needed anywhere
  assign #(T_ACC) rd_v = rd;
  // old data lingers a little after an address change
  assign #(T_HOLD) addr_h = addr_i;
  assign rd_byte = mem[addr_h];
  // remember the byte last driven, so a released bus shows its inverse
  always @*
    if (rd && rd_v)
      held = rd_byte;
  // released bus shows the inverse, so stale data never passes
  always @*
    dq_o = (rd && rd_v) ? rd_byte : (dq_oe_i ? dq_i : ~held);
  // store at the end of the select and write overlap
  always @(negedge wr)
    mem[addr_i] = dq_oe_i ? dq_i : ~dq_i;
endmodule

/* File: sim/async_sram_128k_by_8_test.sv */
// self-checking bench for the async sram host controller
`timescale 1ns/1ps
module async_sram_128k_by_8_test;
  import asc_pkg::*;
  localparam int WP_MIN = ((T_WHZ_NS + T_DW_NS) * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int RD_LAT = RD_CYC + SYNC_CYC + 1;  // taking edge to rvalid, in cycles
  logic              mclk_i = 0;
  logic              rst_i = 1;
  logic              req_i = 0;
  logic              req_we_i = 0;
  logic [ADDR_W-1:0] req_addr_i = '0;
  logic [DATA_W-1:0] req_wd_i = '0;
  logic              ready_o, rvalid_o, cs_n_o, oe_n_o, we_n_o, dq_oe_o, cs_p;
  logic [DATA_W-1:0] rdata_o, dq_o, dq_i;
  logic [ADDR_W-1:0] addr_o, addr_p;
  int                fails = 0;
  int                tests_run = 0;
  int                wlen = 0;

  always #4 mclk_i = ~mclk_i;

  asc_ctrl dut (.mclk_i, .rst_i, .req_i, .req_we_i, .req_addr_i, .req_wd_i, .ready_o,
    .rvalid_o, .rdata_o, .cs_n_o, .oe_n_o, .we_n_o, .addr_o, .dq_o, .dq_oe_o, .dq_i);

  asc_sram_model #(.T_ACC(T_AA_NS), .T_HOLD(T_OH_NS)) mem_u (.cs_n_i(cs_n_o), .oe_n_i(oe_n_o),
    .we_n_i(we_n_o), .addr_i(addr_o), .dq_i(dq_o), .dq_oe_i(dq_oe_o), .dq_o(dq_i));

  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // pin watch at every falling edge outside reset, where the pins have settled
  always @(negedge mclk_i)
  begin
    if (!rst_i)
    begin
      chk(0, !oe_n_o && (dq_oe_o || !we_n_o));
      chk(0, !we_n_o && cs_n_o);
      if (!cs_n_o && !cs_p)
        chk(addr_p, addr_o);
      if (!we_n_o)
        wlen++;
      else if (wlen > 0)
      begin
        chk(1, wlen >= WP_MIN);
        chk(1, wlen * CLK_PS >= T_WP_NS * 1000);
      end
      if (we_n_o)
        wlen = 0;
    end
    cs_p = cs_n_o;
    addr_p = addr_o;
  end

  // one request, held for one edge, then ready low checked to show it was taken
  task automatic do_req(input logic we, input logic [ADDR_W-1:0] a, input logic [7:0] d);
    int n;
    n = 0;
    while (ready_o !== 1'b1 && n < 50)
    begin
      @(negedge mclk_i);
      n++;
    end
    chk(1, ready_o);
    if (ready_o !== 1'b1)
      give_verdict();
    req_i = 1;
    req_we_i = we;
    req_addr_i = a;
    req_wd_i = d;
    @(negedge mclk_i);
    chk(0, ready_o);
    req_i = 0;
  endtask

  // read latency counts access plus the synchroniser on the data pins
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] e);
    int n;
    do_req(0, a, '0);
    n = 0;
    while (rvalid_o !== 1'b1 && n < 20)
    begin
      @(negedge mclk_i);
      n++;
    end
    chk(RD_LAT, n);
    if (rvalid_o !== 1'b1)
      give_verdict();
    chk(e, rdata_o);
    @(negedge mclk_i);
    chk(0, rvalid_o);
  endtask

  task automatic t_reset;
    repeat (4) @(negedge mclk_i);
    chk(6'b111000, {cs_n_o, oe_n_o, we_n_o, dq_oe_o, ready_o, rvalid_o});
    rst_i = 0;
    @(negedge mclk_i);
    chk(1, ready_o);
    $display("reset test done");
  endtask

  // extreme and patterned addresses, written back to back then read
  task automatic t_rw;
    logic [ADDR_W-1:0] a [4];
    logic [7:0]        d [4];
    a = '{17'h0_0000, 17'h1_FFFF, 17'h0_AAAA, 17'h1_5555};
    d = '{8'hA5, 8'h5A, 8'h3C, 8'hC3};
    for (int i = 0; i < 4; i++)
      do_req(1, a[i], d[i]);
    for (int i = 0; i < 4; i++)
      rd(a[i], d[i]);
    $display("write read test done");
  endtask

  // a request made while busy must leave no trace
  task automatic t_refuse;
    do_req(1, 17'h0_0010, 8'h11);
    // let one edge pass so req_i is not lowered and raised in one step
    @(negedge mclk_i);
    req_i = 1;
    req_addr_i = 17'h0_0010;
    req_wd_i = 8'hEE;
    repeat (2) @(negedge mclk_i);
    chk(0, ready_o);
    req_i = 0;
    rd(17'h0_0010, 8'h11);
    repeat (3) @(negedge mclk_i);
    chk(1, cs_n_o);
    $display("refuse test done");
  endtask

  initial
  begin
    t_reset();
    t_rw();
    t_refuse();
    give_verdict();
  end
endmodule
